/* File: dnt_pkg.sv */
package dnt_pkg;
    // =====================================================
    // widths and sizes
    localparam int ACC_W = 48;
    localparam int HOP_W = 32;
    localparam int HOP_N = 32;
    localparam int PH_W = 16;
    localparam int AMP_W = 16;
    localparam int FSC_W = 10;
    localparam int ADDR_W = 8;
    localparam int FIFO_D = 4;
    // =====================================================
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_FTW_LO = 8'h04;
    localparam logic [7:0] OFS_FTW_HI = 8'h08;
    localparam logic [7:0] OFS_DELTA_LO = 8'h0c;
    localparam logic [7:0] OFS_DELTA_HI = 8'h10;
    localparam logic [7:0] OFS_MOD_LO = 8'h14;
    localparam logic [7:0] OFS_MOD_HI = 8'h18;
    localparam logic [7:0] OFS_AMPL = 8'h1c;
    localparam logic [7:0] OFS_FSC = 8'h20;
    localparam logic [7:0] OFS_HOP_SEL = 8'h24;
    localparam logic [7:0] OFS_HOP_IDX = 8'h28;
    localparam logic [7:0] OFS_HOP_FTW = 8'h2c;
    localparam logic [7:0] OFS_STATUS = 8'h30;
    // =====================================================
    // status field positions
    localparam int ST_GATE = 16;
    localparam int ST_FULL = 17;
    // =====================================================
    // reset values and bus response codes
    localparam logic [AMP_W-1:0] RST_AMPL = 16'h7fff;
    localparam logic [FSC_W-1:0] RST_FSC = 10'h000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // =====================================================
    // amplitude and current scaling
    localparam int AMP_SHIFT = 15;
    localparam logic [25:0] FSC_MAX = 26'h00003ff;
    localparam logic [25:0] IOUT_SPAN_UA = 26'h0007d00;
    localparam logic [15:0] IOUT_MIN_UA = 16'h1f40;
    // =====================================================
    // timing
    localparam int CLK_NS = 100;
    localparam int HOP_NS = 260;
    localparam int HOP_CYC = (HOP_NS / CLK_NS < 1) ? 1 : HOP_NS / CLK_NS;
    localparam int RAMP_NS = 1000;
    localparam int RAMP_CYC = (RAMP_NS + CLK_NS - 1) / CLK_NS;
    // =====================================================
    // types
    typedef enum logic [1:0] {HOP_CONT, HOP_DISC, HOP_COH} dnt_hop_mode_t;
    typedef struct packed {
        logic ramp_on_gate;
        logic reset_on_gate;
        logic [1:0] hop_mode;
        logic hop_en;
        logic osc_only;
    } dnt_ctrl_t;
endpackage

/* File: dnt_tone_gen.sv */
`timescale 1ns/1ps
`default_nettype none

// =====================================================
// sample fifo
module dnt_fifo #(
    parameter int W = 16,
    parameter int D = 4
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int PW = (D > 1) ? $clog2(D) : 1;
    localparam int CW = $clog2(D + 1);
    logic [W-1:0] mem_q [D];
    logic [PW-1:0] wp_q, rp_q;
    logic [CW-1:0] cnt_q;
    logic push, pop;

    // honest flags straight from the count
    assign in_ready = (cnt_q != CW'(D));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rp_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // storage write
    always_ff @(posedge aclk) begin
        if (push) begin
            mem_q[wp_q] <= in_data;
        end
    end

    // pointers and count
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= (wp_q == PW'(D - 1)) ? '0 : wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= (rp_q == PW'(D - 1)) ? '0 : rp_q + 1'b1;
            end
            cnt_q <= cnt_q + CW'(push) - CW'(pop);
        end
    end
endmodule

// =====================================================
// tone generator top
module dnt_tone_gen #(
    parameter int FIFO_DEPTH = dnt_pkg::FIFO_D
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [dnt_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [dnt_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // gate pin and baseband input
    input wire logic tx_gate,
    input wire logic [dnt_pkg::AMP_W-1:0] bb_data,
    // samples to the dac core
    output logic [dnt_pkg::AMP_W-1:0] sample_data,
    output logic sample_valid,
    input wire logic sample_ready,
    // analog controls
    output logic analog_enable,
    output logic [dnt_pkg::FSC_W-1:0] fullscale_current_code,
    output logic [15:0] fullscale_output_current
);
    import dnt_pkg::*;

    // =====================================================
    // register state
    dnt_ctrl_t ctrl_q;
    logic [ACC_W-1:0] ftw_q, delta_q, mod_q;
    logic [AMP_W-1:0] constant_amplitude_word_q;
    logic [FSC_W-1:0] fsc_q;
    logic [4:0] hop_sel_q, hop_idx_q;
    logic [HOP_W-1:0] fast_hop_bank_ftw_q [HOP_N];
    logic [ADDR_W-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q, rmux;
    logic rhit, whit, do_wr, hop_go, coh_start;
    logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
    logic [AMP_W-1:0] fifo_out_data;

    function automatic logic [31:0] merge(input logic [31:0] old);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (w_strb_q[i]) begin
                r[8*i +: 8] = w_data_q[8*i +: 8];
            end
        end
        return r;
    endfunction

    // =====================================================
    // axi4-lite write channel: address and data in either order
    assign do_wr = !awready_q && !wready_q && !bvalid_q;
    always_comb begin
        unique case (aw_addr_q)
            OFS_CTRL, OFS_FTW_LO, OFS_FTW_HI, OFS_DELTA_LO, OFS_DELTA_HI, OFS_MOD_LO,
            OFS_MOD_HI, OFS_AMPL, OFS_FSC, OFS_HOP_SEL, OFS_HOP_IDX, OFS_HOP_FTW:
                whit = 1'b1;
            default: whit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            aw_addr_q <= '0;
            w_data_q <= '0;
            w_strb_q <= '0;
        end else begin
            if (s_axi_awvalid && awready_q) begin
                aw_addr_q <= s_axi_awaddr;
                awready_q <= 1'b0;
            end
            if (s_axi_wvalid && wready_q) begin
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
                wready_q <= 1'b0;
            end
            if (do_wr) begin
                bvalid_q <= 1'b1;
                bresp_q <= whit ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end
        end
    end

    // register file writes; the hop select write is the hop itself
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= '0;
            ftw_q <= '0;
            delta_q <= '0;
            mod_q <= '0;
            constant_amplitude_word_q <= RST_AMPL;
            fsc_q <= RST_FSC;
            hop_sel_q <= '0;
            hop_idx_q <= '0;
        end else if (do_wr) begin
            unique case (aw_addr_q)
                OFS_CTRL: ctrl_q <= 6'(merge(32'(ctrl_q)));
                OFS_FTW_LO: ftw_q[31:0] <= merge(ftw_q[31:0]);
                OFS_FTW_HI: ftw_q[47:32] <= 16'(merge(32'(ftw_q[47:32])));
                OFS_DELTA_LO: delta_q[31:0] <= merge(delta_q[31:0]);
                OFS_DELTA_HI: delta_q[47:32] <= 16'(merge(32'(delta_q[47:32])));
                OFS_MOD_LO: mod_q[31:0] <= merge(mod_q[31:0]);
                OFS_MOD_HI: mod_q[47:32] <= 16'(merge(32'(mod_q[47:32])));
                OFS_AMPL: constant_amplitude_word_q <= 16'(merge(32'(constant_amplitude_word_q)));
                OFS_FSC: fsc_q <= 10'(merge(32'(fsc_q)));
                OFS_HOP_SEL: hop_sel_q <= 5'(merge(32'(hop_sel_q)));
                OFS_HOP_IDX: hop_idx_q <= 5'(merge(32'(hop_idx_q)));
                default: ;
            endcase
        end
    end

    // hop word preload through the index register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < HOP_N; i++) begin
                fast_hop_bank_ftw_q[i] <= '0;
            end
        end else if (do_wr && aw_addr_q == OFS_HOP_FTW) begin
            fast_hop_bank_ftw_q[hop_idx_q] <= merge(fast_hop_bank_ftw_q[hop_idx_q]);
        end
    end

    // hops act the next cycle, inside HOP_CYC
    assign hop_go = do_wr && aw_addr_q == OFS_HOP_SEL;
    assign coh_start = do_wr && aw_addr_q == OFS_CTRL && ctrl_q.hop_mode != HOP_COH &&
                       w_strb_q[0] && w_data_q[3:2] == HOP_COH;

    // =====================================================
    // axi4-lite read channel, one cycle after the address is taken
    always_comb begin
        rhit = 1'b1;
        unique case (s_axi_araddr)
            OFS_CTRL: rmux = 32'(ctrl_q);
            OFS_FTW_LO: rmux = ftw_q[31:0];
            OFS_FTW_HI: rmux = 32'(ftw_q[47:32]);
            OFS_DELTA_LO: rmux = delta_q[31:0];
            OFS_DELTA_HI: rmux = 32'(delta_q[47:32]);
            OFS_MOD_LO: rmux = mod_q[31:0];
            OFS_MOD_HI: rmux = 32'(mod_q[47:32]);
            OFS_AMPL: rmux = 32'(constant_amplitude_word_q);
            OFS_FSC: rmux = 32'(fsc_q);
            OFS_HOP_SEL: rmux = 32'(hop_sel_q);
            OFS_HOP_IDX: rmux = 32'(hop_idx_q);
            OFS_HOP_FTW: rmux = fast_hop_bank_ftw_q[hop_idx_q];
            OFS_STATUS: begin
                rmux = 32'(fullscale_current_code);
                rmux[ST_GATE] = tx_gate;
                rmux[ST_FULL] = !fifo_in_ready;
            end
            default: begin
                rmux = '0;
                rhit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end else if (s_axi_arvalid && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rmux;
            rresp_q <= rhit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    // =====================================================
    // main oscillator; a sample is made whenever the fifo takes one
    logic adv, gate_q, gate_rise, ph_reset, wrap;
    logic [ACC_W-1:0] acc_q, rem_q;
    logic [ACC_W:0] rem_sum;
    assign adv = fifo_in_ready;
    assign gate_rise = tx_gate && !gate_q;
    assign ph_reset = gate_rise && ctrl_q.reset_on_gate;
    assign rem_sum = {1'b0, rem_q} + {1'b0, delta_q};
    // modulus of zero disables the fractional part
    assign wrap = (mod_q != '0) && (rem_sum >= {1'b0, mod_q});

    always_ff @(posedge aclk) begin
        if (!aresetn || ph_reset) begin
            acc_q <= '0;
            rem_q <= '0;
        end else if (adv) begin
            acc_q <= acc_q + ftw_q + ACC_W'(wrap);
            if (mod_q == '0) begin
                rem_q <= '0;
            end else begin
                rem_q <= wrap ? ACC_W'(rem_sum - {1'b0, mod_q}) : ACC_W'(rem_sum);
            end
        end
    end

    // =====================================================
    // hop bank: one free-running accumulator per word for coherent mode
    logic [HOP_W-1:0] hop_acc_q [HOP_N];
    logic [HOP_W-1:0] hop_ph_q;
    logic coh;
    assign coh = ctrl_q.hop_mode == HOP_COH;

    for (genvar g = 0; g < HOP_N; g++) begin : g_hop
        // cleared together, so all start at once
        always_ff @(posedge aclk) begin
            if (!aresetn || coh_start) begin
                hop_acc_q[g] <= '0;
            end else if (adv && coh) begin
                hop_acc_q[g] <= hop_acc_q[g] + fast_hop_bank_ftw_q[g];
            end
        end
    end

    // shared phase for continuous and discontinuous hopping
    always_ff @(posedge aclk) begin
        if (!aresetn || ph_reset) begin
            hop_ph_q <= '0;
        end else if (hop_go && ctrl_q.hop_mode == HOP_DISC) begin
            hop_ph_q <= '0;
        end else if (adv) begin
            hop_ph_q <= hop_ph_q + fast_hop_bank_ftw_q[hop_sel_q];
        end
    end

    // =====================================================
    // phase to sine: parabolic approximation, cheap but a few percent off
    logic signed [PH_W-1:0] phase, sine;
    logic signed [PH_W:0] ax;
    logic signed [PH_W+17:0] sprod;
    logic signed [AMP_W-1:0] mult;
    logic signed [2*AMP_W-1:0] mprod;
    logic [AMP_W-1:0] mixed;
    always_comb begin
        if (ctrl_q.hop_en) begin
            phase = coh ? hop_acc_q[hop_sel_q][HOP_W-1 -: PH_W] : hop_ph_q[HOP_W-1 -: PH_W];
        end else begin
            phase = acc_q[ACC_W-1 -: PH_W];
        end
        ax = phase[PH_W-1] ? -(PH_W+1)'(phase) : (PH_W+1)'(phase);
        sprod = (PH_W+18)'(phase) * (PH_W+18)'(18'sh08000 - 18'(ax));
        sprod = sprod >>> 13;
        if (sprod > 34'sh00007fff) begin
            sine = 16'sh7fff;
        end else if (sprod < -34'sh00007fff) begin
            sine = -16'sh7fff;
        end else begin
            sine = PH_W'(sprod);
        end
        mult = ctrl_q.osc_only ? constant_amplitude_word_q : bb_data;
        mprod = sine * mult;
        mixed = AMP_W'(mprod >>> AMP_SHIFT);
    end

    // =====================================================
    // sample fifo and registered output stage
    dnt_fifo #(.W(AMP_W), .D(FIFO_DEPTH)) u_fifo (
        .aclk(aclk),
        .aresetn(aresetn),
        .in_valid(1'b1),
        .in_ready(fifo_in_ready),
        .in_data(tx_gate ? mixed : '0),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );
    logic [AMP_W-1:0] sdata_q;
    logic svalid_q;
    assign fifo_out_ready = !svalid_q || sample_ready;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            svalid_q <= 1'b0;
            sdata_q <= '0;
        end else if (fifo_out_ready) begin
            svalid_q <= fifo_out_valid;
            sdata_q <= fifo_out_data;
        end
    end

    // =====================================================
    // gate follower and full-scale current ramp
    logic [FSC_W-1:0] cur_q;
    logic [15:0] ramp_cnt_q, iout_q;
    logic ramp_tick, en_q;
    logic [25:0] iprod;
    assign ramp_tick = ramp_cnt_q == 16'(RAMP_CYC - 1);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ramp_cnt_q <= '0;
            gate_q <= 1'b0;
            en_q <= 1'b0;
        end else begin
            ramp_cnt_q <= ramp_tick ? '0 : ramp_cnt_q + 1'b1;
            gate_q <= tx_gate;
            en_q <= tx_gate;
        end
    end

    // ramp one code per tick toward target, or down to zero while gated off
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cur_q <= RST_FSC;
        end else if (!ctrl_q.ramp_on_gate) begin
            cur_q <= fsc_q;
        end else if (ramp_tick) begin
            if (tx_gate && cur_q < fsc_q) begin
                cur_q <= cur_q + 1'b1;
            end else if (cur_q > (tx_gate ? fsc_q : '0)) begin
                cur_q <= cur_q - 1'b1;
            end
        end
    end

    // current in microamps, one cycle behind the code
    assign iprod = IOUT_SPAN_UA * 26'(cur_q) / FSC_MAX;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            iout_q <= IOUT_MIN_UA;
        end else begin
            iout_q <= IOUT_MIN_UA + 16'(iprod);
        end
    end

    // =====================================================
    // outputs
    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign sample_data = sdata_q;
    assign sample_valid = svalid_q;
    assign analog_enable = en_q;
    assign fullscale_current_code = cur_q;
    assign fullscale_output_current = iout_q;
endmodule

`default_nettype wire

/* File: dnt_dac_sink.sv */
`timescale 1ns/1ps
`default_nettype none
// =====================================================
// dac core stand-in: takes samples, stalls on request
module dnt_dac_sink (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bench controls
    input wire logic stall,
    input wire logic clr,
    // sample stream
    input wire logic sample_valid,
    input wire logic [dnt_pkg::AMP_W-1:0] sample_data,
    output logic sample_ready,
    // tally of nonzero samples taken
    output logic [15:0] nz_q
);
    import dnt_pkg::*;
    logic ready_q;
    assign sample_ready = ready_q;
    // ready moves only after an edge, as a real core's flow control does
    always_ff @(posedge aclk) begin
        ready_q <= aresetn && !stall;
    end
    // count only samples really taken, so a stall never inflates it
    always_ff @(posedge aclk) begin
        if (!aresetn || clr) begin
            nz_q <= 16'h0000;
        end else if (sample_valid && ready_q && |sample_data) begin
            nz_q <= nz_q + 16'h0001;
        end
    end
endmodule
`default_nettype wire

/* File: dnt_tone_gen_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// =====================================================
// port checks for the tone generator
module dnt_tone_gen_assertions #(
    parameter int FIFO_DEPTH = 4
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    // gate, samples and analog controls
    input wire logic tx_gate,
    input wire logic [dnt_pkg::AMP_W-1:0] sample_data,
    input wire logic sample_valid,
    input wire logic sample_ready,
    input wire logic analog_enable,
    input wire logic [dnt_pkg::FSC_W-1:0] fullscale_current_code,
    input wire logic [15:0] fullscale_output_current
);
    import dnt_pkg::*;
    // =====================================================
    // single domain; reset cancels every attempt
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    a_gate_on: assert property (aresetn && tx_gate |=> analog_enable)
        else $error("analog enable missed the gate");
    a_gate_off: assert property (!tx_gate |=> !analog_enable)
        else $error("analog enable outlived the gate");
    a_current_law: assert property (
        1'b1 |=> fullscale_output_current ==
        16'(32'd8000 + (32'd32000 * 32'($past(fullscale_current_code))) / 32'd1023))
        else $error("output current off the code");
    // fifo and pipeline drain inside twelve samples
    a_gate_mutes: assert property (
        (!tx_gate && sample_ready)[*8] ##1 (!tx_gate && sample_ready)[*4]
        |-> !sample_valid || sample_data == 16'h0000)
        else $error("sample not muted with gate low");
    a_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_sample_hold: assert property (
        sample_valid && !sample_ready |=> sample_valid && $stable(sample_data))
        else $error("sample changed while stalled");
    c_write: cover property (s_axi_awvalid && s_axi_awready);
    c_stall: cover property (sample_valid && !sample_ready);
    c_gate_rise: cover property ($rose(tx_gate));
endmodule
`default_nettype wire

/* File: dnt_tone_gen_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module dnt_tone_gen_tb_top;
    import dnt_pkg::*;
    typedef struct packed {
        logic [7:0] a;
        logic [31:0] d;
        logic [1:0] br;
        logic [31:0] q;
    } dnt_row_t;
    // =====================================================
    // stimulus and observed signals
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_bready = 1'b1, s_axi_rready = 1'b1, tx_gate = 1'b0, stall = 1'b0, clr = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [15:0] bb_data = 16'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic sample_valid, sample_ready, analog_enable;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [31:0] s_axi_rdata, q;
    logic [15:0] sample_data, fullscale_output_current, nz_q;
    logic [9:0] fullscale_current_code;
    int err_total = 0, cmp_count = 0, n;
    // register rows: address, write data, response, read-back
    dnt_row_t rows [9] = '{
        '{OFS_CTRL, 32'hffffffff, 2'h0, 32'h3f}, '{OFS_FTW_LO, 32'h12345678, 2'h0, 32'h12345678},
        '{OFS_FTW_HI, 32'hffffffff, 2'h0, 32'hffff}, '{OFS_DELTA_LO, 32'ha5a5a5a5, 2'h0, 32'ha5a5a5a5},
        '{OFS_MOD_HI, 32'hffffffff, 2'h0, 32'hffff}, '{OFS_AMPL, 32'hffffffff, 2'h0, 32'hffff},
        '{OFS_FSC, 32'hffffffff, 2'h0, 32'h3ff}, '{OFS_HOP_IDX, 32'hffffffff, 2'h0, 32'h1f},
        '{8'h34, 32'h5a5a5a5a, RESP_SLVERR, 32'h0}};
    logic [9:0] fsc_in [3] = '{10'h3ff, 10'h200, 10'h000};
    logic [15:0] fsc_ua [3] = '{16'h9c40, 16'h5dcf, 16'h1f40};
    dnt_tone_gen #(.FIFO_DEPTH(4)) dut (.*);
    dnt_dac_sink u_sink (.*);
    always #50 aclk = ~aclk;
    // =====================================================
    // shared tasks
    task automatic complete_run();
        if (err_total == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rst();
        aresetn <= 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
    endtask
    // bready stays high; done at the bvalid edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        repeat (60) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                rs = s_axi_bresp;
                return;
            end
        end
        err_total++;
        complete_run();
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        repeat (60) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                d = s_axi_rdata;
                rs = s_axi_rresp;
                return;
            end
        end
        err_total++;
        complete_run();
    endtask
    task automatic wo(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] rs;
        wr(a, d, rs);
        chk(rs, RESP_OKAY);
    endtask
    task automatic wait_code(input logic [9:0] e, output int k);
        k = 0;
        while (fullscale_current_code !== e && k < 200) begin
            @(posedge aclk);
            k++;
        end
        chk(fullscale_current_code, e);
        if (fullscale_current_code !== e) complete_run();
    endtask
    // flush, then count nonzero samples taken
    task automatic tone(input logic [31:0] c, input logic [31:0] a, input logic [31:0] s,
                        input logic g, input logic [15:0] b, input logic z);
        tx_gate <= g;
        bb_data <= b;
        wo(OFS_CTRL, c);
        wo(OFS_AMPL, a);
        wo(OFS_HOP_SEL, s);
        repeat (12) @(posedge aclk);
        clr <= 1'b1;
        @(posedge aclk);
        clr <= 1'b0;
        repeat (16) @(posedge aclk);
        chk(nz_q == 16'h0, z);
    endtask
    function automatic logic [31:0] hw(input int i);
        return (i == 3) ? 32'h0 : 32'(i + 1) << 24;
    endfunction
    // =====================================================
    // main sequence
    initial begin
        rst();
        chk(analog_enable, 1'b0);
        chk(fullscale_output_current, IOUT_MIN_UA);
        rd(OFS_AMPL, q, r);
        chk(q, 32'h7fff);
        for (int i = 0; i < 9; i++) begin
            wr(rows[i].a, rows[i].d, r);
            chk(r, rows[i].br);
            rd(rows[i].a, q, r);
            chk(q, rows[i].q);
            chk(r, rows[i].br);
        end
        wr(OFS_STATUS, 32'h0, r);
        chk(r, RESP_SLVERR);
        wo(OFS_CTRL, 32'h0);
        wo(OFS_AMPL, 32'h7fff);
        for (int i = 0; i < 3; i++) begin
            wo(OFS_FSC, 32'(fsc_in[i]));
            wait_code(fsc_in[i], n);
            @(posedge aclk);
            chk(fullscale_output_current, fsc_ua[i]);
        end
        // ramp: three steps take over fifteen cycles
        tx_gate <= 1'b1;
        wo(OFS_CTRL, 32'h20);
        wo(OFS_FSC, 32'h3);
        wait_code(10'h3, n);
        chk(n > 15, 1'b1);
        wo(OFS_FTW_HI, 32'h100);
        wo(OFS_FTW_LO, 32'h0);
        tone(32'h01, 32'h7fff, 0, 1'b1, 16'h0, 1'b0);
        tone(32'h01, 32'h0, 0, 1'b1, 16'h0, 1'b1);
        tone(32'h01, 32'h7fff, 0, 1'b0, 16'h0, 1'b1);
        tone(32'h00, 32'h7fff, 0, 1'b1, 16'h0, 1'b1);
        tone(32'h00, 32'h7fff, 0, 1'b1, 16'h4000, 1'b0);
        for (int i = 0; i < HOP_N; i++) begin
            wo(OFS_HOP_IDX, 32'(i));
            wo(OFS_HOP_FTW, hw(i));
        end
        for (int i = 0; i < HOP_N; i++) begin
            wo(OFS_HOP_IDX, 32'(i));
            rd(OFS_HOP_FTW, q, r);
            chk(q, hw(i));
        end
        tone(32'h0b, 32'h7fff, 3, 1'b1, 16'h0, 1'b1);
        tone(32'h07, 32'h7fff, 3, 1'b1, 16'h0, 1'b1);
        tone(32'h07, 32'h7fff, 5, 1'b1, 16'h0, 1'b0);
        tone(32'h03, 32'h7fff, 5, 1'b1, 16'h0, 1'b0);
        // sink stalls until the fifo refuses, then drains it
        stall <= 1'b1;
        repeat (12) @(posedge aclk);
        rd(OFS_STATUS, q, r);
        chk(q[ST_FULL], 1'b1);
        stall <= 1'b0;
        repeat (12) @(posedge aclk);
        rd(OFS_STATUS, q, r);
        chk(q[ST_FULL], 1'b0);
        chk(q[ST_GATE], 1'b1);
        // frozen phase; a gate rise must zero it
        tone(32'h11, 32'h7fff, 0, 1'b1, 16'h0, 1'b0);
        wo(OFS_FTW_HI, 32'h0);
        tone(32'h11, 32'h7fff, 0, 1'b0, 16'h0, 1'b1);
        tone(32'h11, 32'h7fff, 0, 1'b1, 16'h0, 1'b1);
        rst();
        chk(sample_valid, 1'b0);
        chk(fullscale_output_current, IOUT_MIN_UA);
        rd(OFS_AMPL, q, r);
        chk(q, 32'h7fff);
        complete_run();
    end
endmodule
bind dnt_tone_gen dnt_tone_gen_assertions #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (.*);
`default_nettype wire
